// File: hdl/energy_mode_power_domain_ctrl.sv
// Energy-mode power controller: domain enables, voltage targets, RAM gating, IRQ.
// Assumes Avalon-MM master on core_clk_in and synchronous inputs.
`timescale 1ns/1ns
`default_nettype none
`include "energy_mode_cfg.svh"

module energy_mode_power_domain_ctrl
    import energy_mode_pkg::*;
#(
    parameter int RAM_BLOCKS = 8,
    parameter int SETTLE_CYCLES = `SETTLE_CYC
)
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Mode request
    input wire logic [2:0] mode_req_in,
    input wire logic mode_req_valid_in,
    output logic mode_req_ready_out,
    output logic mode_done_out,
    // Peripheral demand, supply monitor
    input wire logic [3:0] aux_use_in,
    input wire logic low_supply_in,
    // Power and regulator controls
    output domain_en_t domains_out,
    output logic [1:0] vsel_out,
    output logic [RAM_BLOCKS-1:0] ram_off_out,
    output logic irq_out
);

    localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYCLES - 1);

    seq_state_t state_q;
    energy_mode_t cur_mode_q;
    energy_mode_t tgt_mode_q;
    domain_en_t dom_next;
    logic [7:0] settle_q;
    logic [1:0] vsel_act_q;
    logic [1:0] vsel_slp_q;
    logic [RAM_BLOCKS-1:0] ram_off_q;
    logic [`IRQ_BITS-1:0] irq_stat_q;
    logic [`IRQ_BITS-1:0] irq_en_q;
    logic [`IRQ_BITS-1:0] irq_set;
    logic [`IRQ_BITS-1:0] irq_clr;
    logic low_supply_q;
    logic ack_q;
    logic wr_fire;
    logic rd_fire;
    logic [31:0] rd_mux;
    logic [31:0] st_word;
    logic req_ok;

    // Decode of the mode now in force
    domain_decode u_decode
    (
        .mode_in(cur_mode_q),
        .aux_use_in(aux_use_in),
        .domains_out(dom_next)
    );

    // Bus handshake: one wait cycle per access
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign wr_fire = avs_write && ack_q;
    assign rd_fire = avs_read && !ack_q;

    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            ack_q <= 1'b0;
        else
            ack_q <= (avs_read || avs_write) && !ack_q;
    end

    // Status word
    always_comb
    begin
        st_word = 32'h0;
        st_word[`ST_MODE_LSB +: 3] = cur_mode_q;
        st_word[`ST_DOMAIN_LSB +: 7] = domains_out;
        st_word[`ST_VSEL_LSB +: 2] = vsel_out;
        st_word[`ST_BUSY] = (state_q != SEQ_IDLE);
    end

    // Read multiplexer; unmapped and write-only read zero
    always_comb
    begin
        rd_mux = 32'h0;
        case (avs_address)
            `REG_VSEL_ACTIVE: rd_mux[1:0] = vsel_act_q;
            `REG_VSEL_SLEEP: rd_mux[1:0] = vsel_slp_q;
            `REG_RAM_OFF: rd_mux[RAM_BLOCKS-1:0] = ram_off_q;
            `REG_STATUS: rd_mux = st_word;
            `REG_IRQ_STATUS: rd_mux[`IRQ_BITS-1:0] = irq_stat_q;
            `REG_IRQ_ENABLE: rd_mux[`IRQ_BITS-1:0] = irq_en_q;
            default: rd_mux = 32'h0;
        endcase
    end

    // Read data captured in the wait cycle
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            avs_readdata <= 32'h0;
        else if (rd_fire)
            avs_readdata <= rd_mux;
    end

    // RULE9 RULE10 RULE12 voltage selections
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            vsel_act_q <= `RST_VSEL_ACTIVE;
            vsel_slp_q <= `RST_VSEL_SLEEP;
        end
        else if (wr_fire && avs_byteenable[0] && avs_writedata[1:0] != 2'h3)
        begin
            if (avs_address == `REG_VSEL_ACTIVE)
                vsel_act_q <= avs_writedata[1:0];
            if (avs_address == `REG_VSEL_SLEEP)
                vsel_slp_q <= avs_writedata[1:0];
        end
    end

    // RULE14 RAM block power removal, byte lanes honoured
    generate
        for (genvar i = 0; i < RAM_BLOCKS; i++)
        begin : g_ram
            always_ff @(posedge core_clk_in or posedge sys_rst_in)
            begin
                if (sys_rst_in)
                    ram_off_q[i] <= 1'b0;
                else if (wr_fire && avs_address == `REG_RAM_OFF && avs_byteenable[i / 8])
                    ram_off_q[i] <= avs_writedata[i];
            end
        end
    endgenerate

    assign ram_off_out = ram_off_q;

    // Interrupt enable register
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            irq_en_q <= '0;
        else if (wr_fire && avs_address == `REG_IRQ_ENABLE && avs_byteenable[0])
            irq_en_q <= avs_writedata[`IRQ_BITS-1:0];
    end

    // Low-supply edge history
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            low_supply_q <= 1'b0;
        else
            low_supply_q <= low_supply_in;
    end

    // Events and write-one clears
    always_comb
    begin
        irq_set = '0;
        // RULE15 low supply event
        irq_set[`IRQ_LOW_SUPPLY] = low_supply_in && !low_supply_q;
        irq_set[`IRQ_MODE_DONE] = (state_q == SEQ_DONE);
        irq_clr = '0;
        if (wr_fire && avs_address == `REG_IRQ_CLEAR && avs_byteenable[0])
            irq_clr = avs_writedata[`IRQ_BITS-1:0];
    end

    // Sticky status, set beats clear
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            irq_stat_q <= '0;
        else
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end

    // RULE15 level interrupt
    assign irq_out = |(irq_stat_q & irq_en_q);

    // Mode request handshake
    assign mode_req_ready_out = (state_q == SEQ_IDLE);
    assign req_ok = mode_req_in <= `MODE_SHUTOFF;

    // Mode-entry sequencer
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            state_q <= SEQ_IDLE;
            tgt_mode_q <= MODE_RUN;
        end
        else
        begin
            case (state_q)
                SEQ_IDLE:
                begin
                    if (mode_req_valid_in && req_ok)
                    begin
                        tgt_mode_q <= energy_mode_t'(mode_req_in);
                        state_q <= SEQ_APPLY;
                    end
                end
                SEQ_APPLY: state_q <= SEQ_SETTLE;
                SEQ_SETTLE:
                begin
                    if (settle_q == SETTLE_LAST)
                        state_q <= SEQ_DONE;
                end
                SEQ_DONE: state_q <= SEQ_IDLE;
                default: state_q <= SEQ_IDLE;
            endcase
        end
    end

    // Regulator settle counter
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            settle_q <= 8'h0;
        else if (state_q == SEQ_SETTLE)
            settle_q <= settle_q + 8'h1;
        else
            settle_q <= 8'h0;
    end

    // RULE13 mode in force switches at apply
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            cur_mode_q <= MODE_RUN;
        else if (state_q == SEQ_APPLY)
            cur_mode_q <= tgt_mode_q;
    end

    // RULE8 domains track mode and demand
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            domains_out <= '{always_on: 1'b1, base_lp: 1'b1, aux: 4'h0, active: 1'b1};
        else
            domains_out <= dom_next;
    end

    // RULE13 regulator target per mode group
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            vsel_out <= `RST_VSEL_ACTIVE;
        else if (cur_mode_q == MODE_RUN || cur_mode_q == MODE_SLEEP)
            vsel_out <= vsel_act_q;
        else
            vsel_out <= vsel_slp_q;
    end

    // RULE16 completion pulse after settling
    assign mode_done_out = (state_q == SEQ_DONE);

    // Checks

    property p_aon_always;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        domains_out.always_on;
    endproperty
    a_aon_always: assert property (p_aon_always) // RULE1
        else $error("always-on domain dropped");

    property p_shutoff_off;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (cur_mode_q == MODE_SHUTOFF) |=> (!domains_out.base_lp && domains_out.aux == 4'h0);
    endproperty
    a_shutoff_off: assert property (p_shutoff_off) // RULE2
        else $error("low-power domains on in shutoff");

    property p_base_on;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (cur_mode_q != MODE_SHUTOFF) |=> domains_out.base_lp;
    endproperty
    a_base_on: assert property (p_base_on) // RULE3
        else $error("base domain off in run to stop");

    property p_aux_demand;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (cur_mode_q inside {MODE_DEEP_SLEEP, MODE_STOP}) |=>
            (domains_out.aux[2:0] == $past(aux_use_in[2:0]));
    endproperty
    a_aux_demand: assert property (p_aux_demand) // RULE4
        else $error("aux domain does not follow demand");

    property p_aux_e;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (cur_mode_q != MODE_SHUTOFF && (|aux_use_in)) |=> domains_out.aux[3];
    endproperty
    a_aux_e: assert property (p_aux_e) // RULE5
        else $error("aux domain e not powered");

    property p_active_on;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (cur_mode_q inside {MODE_RUN, MODE_SLEEP}) |=> domains_out.active;
    endproperty
    a_active_on: assert property (p_active_on) // RULE6
        else $error("active domain off in run or sleep");

    property p_active_off;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (cur_mode_q inside {MODE_DEEP_SLEEP, MODE_STOP, MODE_SHUTOFF}) |=> !domains_out.active;
    endproperty
    a_active_off: assert property (p_active_off) // RULE7
        else $error("active domain on in low modes");

    property p_vsel_write;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (wr_fire && avs_address == `REG_VSEL_ACTIVE && avs_byteenable[0] && avs_writedata[1:0] != 2'h3)
            |=> (vsel_act_q == $past(avs_writedata[1:0]));
    endproperty
    a_vsel_write: assert property (p_vsel_write) // RULE9
        else $error("run voltage selection not stored");

    property p_vsel_group;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        $changed(cur_mode_q) |=> (vsel_out ==
            (($past(cur_mode_q) inside {MODE_RUN, MODE_SLEEP}) ? $past(vsel_act_q) : $past(vsel_slp_q)));
    endproperty
    a_vsel_group: assert property (p_vsel_group) // RULE13
        else $error("regulator target not switched");

    property p_low_irq;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (low_supply_in && !low_supply_q) |=> irq_stat_q[`IRQ_LOW_SUPPLY] ##0 (irq_en_q[`IRQ_LOW_SUPPLY] == irq_out || irq_out);
    endproperty
    a_low_irq: assert property (p_low_irq) // RULE15
        else $error("low supply not flagged");

    property p_done_ready;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        mode_done_out |-> (cur_mode_q == tgt_mode_q && settle_q == SETTLE_LAST + 8'h1
            && domains_out.base_lp == (cur_mode_q != MODE_SHUTOFF)
            && domains_out.active == (cur_mode_q inside {MODE_RUN, MODE_SLEEP})
            && vsel_out == (($past(cur_mode_q) inside {MODE_RUN, MODE_SLEEP}) ? $past(vsel_act_q) : $past(vsel_slp_q)));
    endproperty
    a_done_ready: assert property (p_done_ready) // RULE16
        else $error("mode done before outputs updated");

endmodule
`default_nettype wire

// File: hdl/energy_mode_cfg.svh
// Constants of the energy-mode power controller: offsets, fields, resets, timing.
// Assumes inclusion by the package and the top module under one guard.
//
// Function
// RULE1 - Always-on domain stays powered in every energy mode, shutoff included.
// RULE2 - Entering shutoff powers off base and all auxiliary low-power domains.
// RULE3 - Base low-power domain stays on in run, sleep, deep sleep and stop.
// RULE4 - In deep sleep and stop, an auxiliary domain is on only while used.
// RULE5 - Auxiliary domain e also powers when domains b, c or d are in use.
// RULE6 - Active domain stays powered throughout run and sleep modes.
// RULE7 - Active domain is off in deep sleep, stop and shutoff, always.
// RULE8 - Domain switching happens in hardware with no software action.
// RULE9 - Two programmable voltage selections: run/sleep and deep-sleep/stop.
// RULE10 - Run/sleep voltage selection resets to the high level.
// RULE11 - Software keeps the core clock at or below 40 MHz at mid level.
// RULE12 - The low voltage level may be chosen for deep sleep and stop.
// RULE13 - Each mode change retargets the regulator to the destination group's level.
// RULE14 - Per-block power removal for RAM blocks marked unused.
// RULE15 - Low supply from the buck monitor raises a software-visible interrupt.
// RULE16 - Mode entry completes only after domains and voltage target are updated.
`ifndef ENERGY_MODE_CFG_SVH
`define ENERGY_MODE_CFG_SVH

// Energy mode encodings
`define MODE_RUN 3'h0
`define MODE_SLEEP 3'h1
`define MODE_DEEP_SLEEP 3'h2
`define MODE_STOP 3'h3
`define MODE_SHUTOFF 3'h4

// Voltage level encodings
`define VLVL_LOW 2'h0
`define VLVL_MID 2'h1
`define VLVL_HIGH 2'h2

// Register byte offsets
`define REG_VSEL_ACTIVE 5'h00
`define REG_VSEL_SLEEP 5'h04
`define REG_RAM_OFF 5'h08
`define REG_STATUS 5'h0c
`define REG_IRQ_STATUS 5'h10
`define REG_IRQ_CLEAR 5'h14
`define REG_IRQ_ENABLE 5'h18

// Reset values
`define RST_VSEL_ACTIVE `VLVL_HIGH
`define RST_VSEL_SLEEP `VLVL_LOW

// Interrupt bit positions
`define IRQ_LOW_SUPPLY 0
`define IRQ_MODE_DONE 1
`define IRQ_BITS 2

// Status field positions
`define ST_MODE_LSB 0
`define ST_DOMAIN_LSB 4
`define ST_VSEL_LSB 12
`define ST_BUSY 15

// Regulator settling time and clock period in ns
`define SETTLE_NS 200
`define CLK_PERIOD_NS 4
`define SETTLE_CYC ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: hdl/energy_mode_pkg.sv
// Types shared by the energy-mode power controller.
// Assumes the constants header is on the include path.
`include "energy_mode_cfg.svh"

package energy_mode_pkg;

    typedef enum logic [2:0] {
        MODE_RUN = `MODE_RUN,
        MODE_SLEEP = `MODE_SLEEP,
        MODE_DEEP_SLEEP = `MODE_DEEP_SLEEP,
        MODE_STOP = `MODE_STOP,
        MODE_SHUTOFF = `MODE_SHUTOFF
    } energy_mode_t;

    typedef enum logic [1:0] {
        VLVL_LOW = `VLVL_LOW,
        VLVL_MID = `VLVL_MID,
        VLVL_HIGH = `VLVL_HIGH
    } vlevel_t;

    // Aux bits 0..3 are domains b, c, d, e
    typedef struct packed {
        logic always_on;
        logic base_lp;
        logic [3:0] aux;
        logic active;
    } domain_en_t;

    // Gray codes along idle, apply, settle, done
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'h0,
        SEQ_APPLY = 2'h1,
        SEQ_SETTLE = 2'h3,
        SEQ_DONE = 2'h2
    } seq_state_t;

endpackage

// File: hdl/domain_decode.sv
// Maps an energy mode and auxiliary-domain use to power-domain enables.
// Pure combinational; the caller registers the result.
`timescale 1ns/1ns
`default_nettype none

module domain_decode
    import energy_mode_pkg::*;
(
    // Mode and demand
    input wire energy_mode_t mode_in,
    input wire logic [3:0] aux_use_in,
    // Enables
    output domain_en_t domains_out
);

    logic low_power_on;
    logic run_group;

    assign low_power_on = (mode_in != MODE_SHUTOFF);
    assign run_group = (mode_in == MODE_RUN) || (mode_in == MODE_SLEEP);

    // Decode of every domain
    always_comb
    begin
        // RULE1 always-on domain
        domains_out.always_on = 1'b1;
        // RULE2 RULE3 base domain
        domains_out.base_lp = low_power_on;
        // RULE4 aux on demand
        domains_out.aux[2:0] = aux_use_in[2:0] & {3{low_power_on}};
        // RULE5 e follows b, c, d
        domains_out.aux[3] = low_power_on && ((|aux_use_in[2:0]) || aux_use_in[3]);
        // RULE6 RULE7 active domain
        domains_out.active = run_group;
    end

endmodule
`default_nettype wire

// File: verif/periph_model.sv
// Far-side model: peripheral enable sources and the buck supply monitor.
// Assumes the bench commands demand and low supply; outputs move on core clock.
`timescale 1ns/1ns
`default_nettype none

module periph_model
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Commands from the bench
    input wire logic [3:0] aux_req_in,
    input wire logic low_req_in,
    // Lines toward the controller
    output logic [3:0] aux_use_out,
    output logic low_supply_out
);
    // Enable sources settle one cycle after a command
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            aux_use_out <= 4'h0;
            low_supply_out <= 1'b0;
        end
        else
        begin
            aux_use_out <= aux_req_in;
            low_supply_out <= low_req_in;
        end
    end
endmodule

`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the energy-mode power controller.
// Assumes the controller runs with SETTLE_CYCLES of 2 and the far-side model.
`timescale 1ns/1ns
`default_nettype none
`include "energy_mode_cfg.svh"

module tb
    import energy_mode_pkg::*;
;
    localparam int S = 2;
    logic core_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h1;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [2:0] mode_req_in = 3'h0;
    logic mode_req_valid_in = 1'b0;
    logic mode_req_ready_out;
    logic mode_done_out;
    logic [3:0] aux_use_in;
    logic low_supply_in;
    domain_en_t domains_out;
    logic [1:0] vsel_out;
    logic [7:0] ram_off_out;
    logic irq_out;
    logic [3:0] aux_req = 4'h0;
    logic low_req = 1'b0;
    logic [31:0] seed = 32'hb684;
    logic [31:0] r;
    logic [1:0] vact = 2'h2;
    logic [1:0] vslp = 2'h0;
    int failures = 0;
    int samples_checked = 0;

    // Clock at 4 ns period
    always #2 core_clk_in = ~core_clk_in;

    energy_mode_power_domain_ctrl #(.RAM_BLOCKS(8), .SETTLE_CYCLES(S)) i_energy_mode_power_domain_ctrl (
        .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .mode_req_in(mode_req_in), .mode_req_valid_in(mode_req_valid_in),
        .mode_req_ready_out(mode_req_ready_out), .mode_done_out(mode_done_out),
        .aux_use_in(aux_use_in), .low_supply_in(low_supply_in), .domains_out(domains_out),
        .vsel_out(vsel_out), .ram_off_out(ram_off_out), .irq_out(irq_out));

    periph_model i_periph_model (.clk_in(core_clk_in), .rst_in(sys_rst_in), .aux_req_in(aux_req),
        .low_req_in(low_req), .aux_use_out(aux_use_in), .low_supply_out(low_supply_in));

    // Xorshift source
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected domain enables for a mode and demand
    function automatic domain_en_t exp_dom(input logic [2:0] m, input logic [3:0] a);
        domain_en_t d;
        d.always_on = 1'b1;
        d.base_lp = (m != 3'h4);
        d.active = (m <= 3'h1);
        d.aux = (m == 3'h4) ? 4'h0 : {a[3] | (|a[2:0]), a[2:0]};
        return d;
    endfunction

    // Expected regulator target for a mode
    function automatic logic [1:0] exp_v(input logic [2:0] m);
        return (m <= 3'h1) ? vact : vslp;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Avalon access: raise after an edge, hold until waitrequest low, take data there
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk_in);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        do
            @(posedge core_clk_in);
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] wd);
        logic [31:0] d;
        bus(1'b1, a, wd, d);
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, a, 32'h0, d);
        check(d, exp);
    endtask

    // Mode request; dropped codes must give no completion
    task automatic enter(input logic [2:0] m, input logic drop);
        int n;
        n = 0;
        mode_req_in <= m;
        mode_req_valid_in <= 1'b1;
        @(negedge core_clk_in);
        check(mode_req_ready_out, 1'b1);
        @(posedge core_clk_in);
        mode_req_valid_in <= 1'b0;
        do
        begin
            @(negedge core_clk_in);
            n++;
        end
        while (n < 20 && mode_done_out !== 1'b1);
        check(n, drop ? 20 : 2 + S);
        if (!drop)
        begin
            check(domains_out, exp_dom(m, aux_req));
            check(vsel_out, exp_v(m));
        end
        @(posedge core_clk_in);
    endtask

    // Watchdog far beyond the expected run length
    initial
    begin
        #40000;
        failures++;
        results();
    end

    initial
    begin
        repeat (2) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        @(negedge core_clk_in);
        check(domains_out, exp_dom(3'h0, 4'h0));
        check(vsel_out, 2'h2);
        check({ram_off_out, irq_out}, 9'h0);
        @(posedge core_clk_in);
        rd_chk(`REG_VSEL_ACTIVE, 32'h2);
        rd_chk(`REG_VSEL_SLEEP, 32'h0);
        rd_chk(`REG_IRQ_ENABLE, 32'h0);
        rd_chk(5'h1c, 32'h0);
        $display("test reset done");
        // Random modes, demand and voltage selections
        repeat (14)
        begin
            r = rnd();
            aux_req <= r[7:4];
            wr(r[2] ? `REG_VSEL_ACTIVE : `REG_VSEL_SLEEP, {30'h0, r[1:0]});
            if (r[1:0] != 2'h3 && r[2])
                vact = r[1:0];
            if (r[1:0] != 2'h3 && !r[2])
                vslp = r[1:0];
            rd_chk(`REG_VSEL_ACTIVE, {30'h0, vact});
            enter((r[10:8] > 3'h4) ? r[10:8] - 3'h4 : r[10:8], 1'b0);
            rd_chk(`REG_STATUS, {16'h0, 1'b0, 1'b0, exp_v(mode_req_in), 1'b0, exp_dom(mode_req_in, aux_req),
                1'b0, mode_req_in});
        end
        wr(`REG_VSEL_SLEEP, 32'h0);
        vslp = 2'h0;
        enter(3'h4, 1'b0);
        enter(3'h2, 1'b0);
        enter(3'h1, 1'b0);
        $display("test modes done");
        for (int m = 5; m < 8; m++)
            enter(3'(m), 1'b1);
        $display("test dropped done");
        // Demand changes in stop with no software action
        enter(3'h3, 1'b0);
        for (int k = 0; k < 5; k++)
        begin
            aux_req <= (k == 4) ? 4'h0 : 4'(1 << k);
            repeat (3) @(negedge core_clk_in);
            check(domains_out, exp_dom(3'h3, aux_req));
            check(domains_out.aux[3], (k < 4));
            @(posedge core_clk_in);
        end
        $display("test demand done");
        // RAM gating mask and a write without lane 0
        r = rnd();
        wr(`REG_RAM_OFF, {24'h0, r[7:0]});
        @(negedge core_clk_in);
        check(ram_off_out, r[7:0]);
        @(posedge core_clk_in);
        avs_byteenable <= 4'h2;
        wr(`REG_RAM_OFF, 32'h0);
        avs_byteenable <= 4'h1;
        @(negedge core_clk_in);
        check(ram_off_out, r[7:0]);
        @(posedge core_clk_in);
        $display("test ram done");
        // Low supply interrupt: enabled, cleared, masked
        wr(`REG_IRQ_CLEAR, 32'h3);
        wr(`REG_IRQ_ENABLE, 32'h1);
        low_req <= 1'b1;
        repeat (3) @(negedge core_clk_in);
        check(irq_out, 1'b1);
        @(posedge core_clk_in);
        low_req <= 1'b0;
        rd_chk(`REG_IRQ_STATUS, 32'h1);
        wr(`REG_IRQ_CLEAR, 32'h1);
        @(negedge core_clk_in);
        check(irq_out, 1'b0);
        @(posedge core_clk_in);
        wr(`REG_IRQ_ENABLE, 32'h0);
        low_req <= 1'b1;
        repeat (3) @(negedge core_clk_in);
        check(irq_out, 1'b0);
        @(posedge core_clk_in);
        rd_chk(`REG_IRQ_STATUS, 32'h1);
        rd_chk(`REG_IRQ_CLEAR, 32'h0);
        wr(`REG_IRQ_ENABLE, 32'h2);
        enter(3'h0, 1'b0);
        @(negedge core_clk_in);
        check(irq_out, 1'b1);
        @(posedge core_clk_in);
        $display("test irq done");
        results();
    end
endmodule

`default_nettype wire
